/* File: rtl/shp_handler_regs.sv */
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ns
module shp_handler_regs
    import shp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [SHP_NUM_EXC-1:0] pend_set,
    input wire logic [SHP_NUM_EXC-1:0] pend_clr,
    input wire logic [SHP_NUM_EXC-1:0] act_set,
    input wire logic [SHP_NUM_EXC-1:0] act_clr,
    input wire logic mon_act_in,
    input wire logic [2:0] fault_req,
    output logic [2:0] fault_take,
    output logic hard_fault,
    output logic [SHP_NUM_EXC-1:0] pend_out,
    output logic [SHP_NUM_EXC-1:0] act_out,
    output logic [2:0] enable_out,
    output logic [47:0] prio_out
);
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire wr_one = reg_wr && (reg_addr == SHP_OFF_PRIO_ONE);
    wire wr_two = reg_wr && (reg_addr == SHP_OFF_PRIO_TWO);
    wire wr_three = reg_wr && (reg_addr == SHP_OFF_PRIO_THREE);
    wire wr_ctrl = reg_wr && (reg_addr == SHP_OFF_CTRL);

    // ----------------------------------------
    // priority fields
    // ----------------------------------------
    logic [7:0] memfault_priority;
    logic [7:0] busfault_priority;
    logic [7:0] usagefault_priority;
    logic [7:0] supervisor_call_priority;
    logic [7:0] pendable_service_priority;
    logic [7:0] tick_priority;

    function automatic logic [7:0] lane(input logic [31:0] w, input int n);
        lane = w[8*n +: 8];
    endfunction

    shp_prio_field u_mem (.sys_clk(sys_clk), .sys_rst(sys_rst), .wr_en(wr_one),
        .wr_byte(lane(reg_wdata, SHP_LANE_MEM)), .prio(memfault_priority));
    shp_prio_field u_bus (.sys_clk(sys_clk), .sys_rst(sys_rst), .wr_en(wr_one),
        .wr_byte(lane(reg_wdata, SHP_LANE_BUS)), .prio(busfault_priority));
    shp_prio_field u_usg (.sys_clk(sys_clk), .sys_rst(sys_rst), .wr_en(wr_one),
        .wr_byte(lane(reg_wdata, SHP_LANE_USG)), .prio(usagefault_priority));
    shp_prio_field u_svc (.sys_clk(sys_clk), .sys_rst(sys_rst), .wr_en(wr_two),
        .wr_byte(lane(reg_wdata, SHP_LANE_SVC)), .prio(supervisor_call_priority));
    shp_prio_field u_psv (.sys_clk(sys_clk), .sys_rst(sys_rst), .wr_en(wr_three),
        .wr_byte(lane(reg_wdata, SHP_LANE_PSV)), .prio(pendable_service_priority));
    shp_prio_field u_tick (.sys_clk(sys_clk), .sys_rst(sys_rst), .wr_en(wr_three),
        .wr_byte(lane(reg_wdata, SHP_LANE_TICK)), .prio(tick_priority));

    // ----------------------------------------
    // enables
    // ----------------------------------------
    logic [2:0] enable_reg;
    logic [2:0] enable_next;
    // order: [0] mem, [1] bus, [2] usage
    assign enable_next = wr_ctrl ? {reg_wdata[SHP_BIT_USG_EN], reg_wdata[SHP_BIT_BUS_EN],
        reg_wdata[SHP_BIT_MEM_EN]} : enable_reg;

    // ----------------------------------------
    // pending and active flags
    // ----------------------------------------
    // one driver per bit (flag instance or tie-off), so nets rather than variables
    wire [SHP_NUM_EXC-1:0] pend_flag;
    wire [SHP_NUM_EXC-1:0] act_flag;
    logic [SHP_NUM_EXC-1:0] pend_wval;
    logic [SHP_NUM_EXC-1:0] act_wval;
    logic [SHP_NUM_EXC-1:0] pend_impl;
    // pendable service and tick pending bits live elsewhere
    assign pend_impl = 6'b00_1111;
    assign pend_wval = {2'b00, reg_wdata[SHP_BIT_SVC_PEND], reg_wdata[SHP_BIT_USG_PEND],
        reg_wdata[SHP_BIT_BUS_PEND], reg_wdata[SHP_BIT_MEM_PEND]};
    assign act_wval = {reg_wdata[SHP_BIT_TICK_ACT], reg_wdata[SHP_BIT_PSV_ACT],
        reg_wdata[SHP_BIT_SVC_ACT], reg_wdata[SHP_BIT_USG_ACT],
        reg_wdata[SHP_BIT_BUS_ACT], reg_wdata[SHP_BIT_MEM_ACT]};

    // escalation: a disabled fault handler never pends its own flag
    wire [2:0] fault_own = fault_req & enable_reg;
    wire [SHP_NUM_EXC-1:0] pend_set_eff = pend_set | {3'b000, fault_own};

    genvar g;
    generate
        for (g = 0; g < SHP_NUM_EXC; g++) begin : g_flag
            if (g < 4) begin : g_pend
                shp_flag_bit u_pend (.sys_clk(sys_clk), .sys_rst(sys_rst),
                    .sw_wr(wr_ctrl && pend_impl[g]), .sw_val(pend_wval[g]),
                    .hw_set(pend_set_eff[g]), .hw_clr(pend_clr[g]), .flag(pend_flag[g]));
            end else begin : g_nopend
                assign pend_flag[g] = 1'b0;
            end
            shp_flag_bit u_act (.sys_clk(sys_clk), .sys_rst(sys_rst),
                .sw_wr(wr_ctrl), .sw_val(act_wval[g]),
                .hw_set(act_set[g]), .hw_clr(act_clr[g]), .flag(act_flag[g]));
        end
    endgenerate

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic mon_sync_reg;
    logic [31:0] ctrl_word;
    always_comb begin
        ctrl_word = SHP_WORD_ZERO;
        ctrl_word[SHP_BIT_USG_EN] = enable_reg[2];
        ctrl_word[SHP_BIT_BUS_EN] = enable_reg[1];
        ctrl_word[SHP_BIT_MEM_EN] = enable_reg[0];
        ctrl_word[SHP_BIT_SVC_PEND] = pend_flag[SHP_EX_SVC];
        ctrl_word[SHP_BIT_BUS_PEND] = pend_flag[SHP_EX_BUS];
        ctrl_word[SHP_BIT_MEM_PEND] = pend_flag[SHP_EX_MEM];
        ctrl_word[SHP_BIT_USG_PEND] = pend_flag[SHP_EX_USG];
        ctrl_word[SHP_BIT_TICK_ACT] = act_flag[SHP_EX_TICK];
        ctrl_word[SHP_BIT_PSV_ACT] = act_flag[SHP_EX_PSV];
        ctrl_word[SHP_BIT_MON_ACT] = mon_sync_reg;
        ctrl_word[SHP_BIT_SVC_ACT] = act_flag[SHP_EX_SVC];
        ctrl_word[SHP_BIT_USG_ACT] = act_flag[SHP_EX_USG];
        ctrl_word[SHP_BIT_BUS_ACT] = act_flag[SHP_EX_BUS];
        ctrl_word[SHP_BIT_MEM_ACT] = act_flag[SHP_EX_MEM];
    end

    logic [31:0] rd_sel;
    // reserved top byte of bank one reads zero
    assign rd_sel = (reg_addr == SHP_OFF_PRIO_ONE) ?
            {8'h00, usagefault_priority, busfault_priority, memfault_priority} :
        (reg_addr == SHP_OFF_PRIO_TWO) ? {supervisor_call_priority, 24'h000000} :
        (reg_addr == SHP_OFF_PRIO_THREE) ?
            {tick_priority, pendable_service_priority, 16'h0000} :
        (reg_addr == SHP_OFF_CTRL) ? ctrl_word : SHP_WORD_ZERO;

    // ----------------------------------------
    // registers and outputs
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            enable_reg <= 3'b000;
            mon_sync_reg <= 1'b0;
            reg_rdata <= SHP_WORD_ZERO;
            fault_take <= 3'b000;
            hard_fault <= 1'b0;
            pend_out <= '0;
            act_out <= '0;
            enable_out <= 3'b000;
            prio_out <= '0;
        end else begin
            enable_reg <= enable_next;
            mon_sync_reg <= mon_act_in;
            reg_rdata <= reg_rd ? rd_sel : SHP_WORD_ZERO;
            fault_take <= fault_own;
            hard_fault <= |(fault_req & ~enable_reg);
            pend_out <= pend_flag;
            act_out <= act_flag;
            enable_out <= enable_reg;
            prio_out <= {tick_priority, pendable_service_priority, supervisor_call_priority,
                usagefault_priority, busfault_priority, memfault_priority};
        end
    end
endmodule

/* File: common/shp_pkg.sv */
// Notes on behaviour
// - bank one byte 0: memfault priority
// - bank one byte 1: busfault priority
// - bank one byte 2: usagefault; top byte reserved
// - bank two top byte: supervisor call priority
// - bank three byte 2: pendable service priority
// - bank three top byte: tick priority
// - enable bits for usage, bus, memfault handlers
// - fault on disabled handler escalates to hard fault
// - bits 15..12 show pending; writes change them
// - active flags read 1 while exception active
// - bit 8 shows debug monitor active
// - writes to active flags change active status
// - priority fields keep upper nibble only
package shp_pkg;
    // ----------------------------------------
    // register offsets (word aligned)
    // ----------------------------------------
    localparam logic [3:0] SHP_OFF_PRIO_ONE = 4'h0;
    localparam logic [3:0] SHP_OFF_PRIO_TWO = 4'h4;
    localparam logic [3:0] SHP_OFF_PRIO_THREE = 4'h8;
    localparam logic [3:0] SHP_OFF_CTRL = 4'hC;
    // ----------------------------------------
    // control/state bit positions
    // ----------------------------------------
    localparam int SHP_BIT_USG_EN = 18;
    localparam int SHP_BIT_BUS_EN = 17;
    localparam int SHP_BIT_MEM_EN = 16;
    localparam int SHP_BIT_SVC_PEND = 15;
    localparam int SHP_BIT_BUS_PEND = 14;
    localparam int SHP_BIT_MEM_PEND = 13;
    localparam int SHP_BIT_USG_PEND = 12;
    localparam int SHP_BIT_TICK_ACT = 11;
    localparam int SHP_BIT_PSV_ACT = 10;
    localparam int SHP_BIT_MON_ACT = 8;
    localparam int SHP_BIT_SVC_ACT = 7;
    localparam int SHP_BIT_USG_ACT = 3;
    localparam int SHP_BIT_BUS_ACT = 1;
    localparam int SHP_BIT_MEM_ACT = 0;
    // ----------------------------------------
    // priority byte lanes and reset values
    // ----------------------------------------
    localparam int SHP_LANE_MEM = 0;
    localparam int SHP_LANE_BUS = 1;
    localparam int SHP_LANE_USG = 2;
    localparam int SHP_LANE_SVC = 3;
    localparam int SHP_LANE_PSV = 2;
    localparam int SHP_LANE_TICK = 3;
    localparam logic [3:0] SHP_PRIO_RESET = 4'h0;
    localparam logic [31:0] SHP_WORD_ZERO = 32'h0000_0000;
    // flag vector index order: mem, bus, usg, svc, psv, tick
    localparam int SHP_NUM_EXC = 6;
    localparam int SHP_EX_MEM = 0;
    localparam int SHP_EX_BUS = 1;
    localparam int SHP_EX_USG = 2;
    localparam int SHP_EX_SVC = 3;
    localparam int SHP_EX_PSV = 4;
    localparam int SHP_EX_TICK = 5;
endpackage

/* File: rtl/shp_prio_field.sv */
`timescale 1ns/1ns
// one priority field; only upper nibble is stored
module shp_prio_field
    import shp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [7:0] wr_byte,
    output logic [7:0] prio
);
    logic [3:0] nib_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            nib_reg <= SHP_PRIO_RESET;
        end else if (wr_en) begin
            nib_reg <= wr_byte[7:4];
        end
    end

    assign prio = {nib_reg, 4'h0};
endmodule

/* File: rtl/shp_flag_bit.sv */
`timescale 1ns/1ns
// core-set/clear flag with software write; core set wins, software write beats core clear
module shp_flag_bit (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sw_wr,
    input wire logic sw_val,
    input wire logic hw_set,
    input wire logic hw_clr,
    output logic flag
);
    logic flag_reg;
    logic flag_next;

    // set beats any clear so an event is never lost
    assign flag_next = hw_set ? 1'b1 : (sw_wr ? sw_val : (hw_clr ? 1'b0 : flag_reg));

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
endmodule

/* File: testbench/shp_handler_regs_chk.sv */
`timescale 1ns/1ns
// ----------------------------------------
// port checker
// ----------------------------------------
module shp_handler_regs_chk
    import shp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [SHP_NUM_EXC-1:0] act_set,
    input wire logic mon_act_in,
    input wire logic [2:0] fault_req,
    input wire logic [2:0] fault_take,
    input wire logic hard_fault,
    input wire logic [SHP_NUM_EXC-1:0] pend_out,
    input wire logic [SHP_NUM_EXC-1:0] act_out,
    input wire logic [2:0] enable_out,
    input wire logic [47:0] prio_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd(logic [3:0] a); $past(reg_rd) && $past(reg_addr) == a; endsequence
    sequence s_ctrl_wr; reg_wr && reg_addr == SHP_OFF_CTRL; endsequence
    // guard: enable_out lags the enable bits by one cycle
    property p_escalate;
        fault_req[0] && !enable_out[0] && !$past(reg_wr) && !$past(reg_wr, 2) |=> hard_fault;
    endproperty
    property p_take;
        fault_req[1] && enable_out[1] && !$past(reg_wr) && !$past(reg_wr, 2) |=> fault_take[1];
    endproperty
    property p_rst; $fell(sys_rst) |-> reg_rdata == 0 && act_out == 0 && prio_out == 0; endproperty
    property p_nib; (prio_out & 48'h0F0F_0F0F_0F0F) == 48'h0; endproperty
    property p_one; s_rd(SHP_OFF_PRIO_ONE) |-> reg_rdata[31:24] == 8'h00; endproperty
    property p_two; s_rd(SHP_OFF_PRIO_TWO) |-> reg_rdata[23:0] == 24'h000000; endproperty
    property p_mon; s_rd(SHP_OFF_CTRL) |-> reg_rdata[8] == $past(mon_act_in, 2); endproperty
    property p_en; s_ctrl_wr |-> ##2 enable_out == $past(reg_wdata[18:16], 2); endproperty
    property p_pend; fault_take[0] |=> pend_out[SHP_EX_MEM]; endproperty
    property p_act; act_set[SHP_EX_USG] |-> ##2 act_out[SHP_EX_USG]; endproperty
    a_escalate: assert property (p_escalate) else $error("no hard fault");
    a_take: assert property (p_take) else $error("enabled fault not taken");
    a_rst: assert property (p_rst) else $error("outputs not clear");
    a_nib: assert property (p_nib) else $error("low nibble set");
    a_one: assert property (p_one) else $error("bank one top byte set");
    a_two: assert property (p_two) else $error("bank two low bytes set");
    a_mon: assert property (p_mon) else $error("monitor bit wrong");
    a_en: assert property (p_en) else $error("enable bits wrong");
    a_pend: assert property (p_pend) else $error("pending not set");
    a_act: assert property (p_act) else $error("active not set");
endmodule

/* File: testbench/tb_shp_handler_regs.sv */
`timescale 1ns/1ns
// ----------------------------------------
// register bench
// ----------------------------------------
module tb_shp_handler_regs
    import shp_pkg::*;
();
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [5:0] pend_set = 6'h00;
    logic [5:0] pend_clr = 6'h00;
    logic [5:0] act_set = 6'h00;
    logic [5:0] act_clr = 6'h00;
    logic mon_act_in = 1'b0;
    logic [2:0] fault_req = 3'h0;
    logic [2:0] fault_take;
    logic hard_fault;
    logic [5:0] pend_out;
    logic [5:0] act_out;
    logic [2:0] enable_out;
    logic [47:0] prio_out;
    int error_cnt = 0;
    int checks_done = 0;
    always #4 sys_clk = ~sys_clk;
    shp_handler_regs shp_handler_regs_i (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .pend_set, .pend_clr, .act_set, .act_clr, .mon_act_in,
        .fault_req, .fault_take, .hard_fault, .pend_out, .act_out, .enable_out, .prio_out);
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        check({16'h0000, reg_rdata}, {16'h0000, exp});
    endtask
    // single-bit change keeps every other control bit as read
    task automatic rmw(input logic [3:0] a, input logic [31:0] clr, set);
        logic [31:0] cur;
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        cur = reg_rdata;
        wr(a, (cur & ~clr) | set);
    endtask
    // one-cycle core events, outputs looked at half a cycle after
    task automatic pulse(input logic [5:0] ps, pc, as, ac, input logic [2:0] fr);
        @(posedge sys_clk);
        {pend_set, pend_clr, act_set, act_clr, fault_req} <= {ps, pc, as, ac, fr};
        @(posedge sys_clk);
        {pend_set, pend_clr, act_set, act_clr, fault_req} <= 27'h0;
        @(negedge sys_clk);
    endtask
    task automatic rst_check;
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 16; i += 4) begin
            rd(4'(i), SHP_WORD_ZERO);
        end
        check({act_out, pend_out, prio_out[35:0]}, 48'h0);
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        rst_check();
        wr(SHP_OFF_PRIO_ONE, 32'hFFFF_FFFF);
        rd(SHP_OFF_PRIO_ONE, 32'h00F0_F0F0);
        wr(SHP_OFF_PRIO_ONE, 32'h1234_5678);
        wr(4'h1, 32'hFFFF_FFFF);
        rd(4'h1, SHP_WORD_ZERO);
        rd(SHP_OFF_PRIO_ONE, 32'h0030_5070);
        wr(SHP_OFF_PRIO_TWO, 32'hFFFF_FFFF);
        rd(SHP_OFF_PRIO_TWO, 32'hF000_0000);
        wr(SHP_OFF_PRIO_THREE, 32'hFFFF_FFFF);
        rd(SHP_OFF_PRIO_THREE, 32'hF0F0_0000);
        check(prio_out, 48'hF0F0_F030_5070);
        for (int i = 0; i < 3; i++) begin
            pulse(6'h00, 6'h00, 6'h00, 6'h00, 3'(1 << i));
            check({44'h0, fault_take, hard_fault}, 48'h1);
        end
        wr(SHP_OFF_CTRL, 32'h0007_0000);
        rd(SHP_OFF_CTRL, 32'h0007_0000);
        pulse(6'h00, 6'h00, 6'h00, 6'h00, 3'h7);
        check({45'h0, fault_take}, 48'h7);
        rd(SHP_OFF_CTRL, 32'h0007_7000);
        wr(SHP_OFF_CTRL, 32'h0007_8000);
        rd(SHP_OFF_CTRL, 32'h0007_8000);
        check({42'h0, pend_out}, 48'h08);
        wr(SHP_OFF_CTRL, 32'h0007_0C8B);
        rd(SHP_OFF_CTRL, 32'h0007_0C8B);
        check({42'h0, act_out}, 48'h3F);
        pulse(6'h00, 6'h00, 6'h00, 6'h3F, 3'h0);
        rd(SHP_OFF_CTRL, 32'h0007_0000);
        pulse(6'h0F, 6'h00, 6'h3F, 6'h3F, 3'h0);
        rd(SHP_OFF_CTRL, 32'h0007_FC8B);
        pulse(6'h00, 6'h0F, 6'h00, 6'h3F, 3'h0);
        rd(SHP_OFF_CTRL, 32'h0007_0000);
        @(posedge sys_clk) mon_act_in <= 1'b1;
        rd(SHP_OFF_CTRL, 32'h0007_0100);
        @(posedge sys_clk) mon_act_in <= 1'b0;
        rd(SHP_OFF_CTRL, 32'h0007_0000);
        wr(SHP_OFF_CTRL, 32'h0005_0C8B);
        pulse(6'h00, 6'h00, 6'h00, 6'h00, 3'h2);
        check({44'h0, fault_take, hard_fault}, 48'h1);
        rmw(SHP_OFF_CTRL, 32'h0000_0000, 32'h0002_0000);
        rd(SHP_OFF_CTRL, 32'h0007_0C8B);
        pulse(6'h00, 6'h00, 6'h00, 6'h00, 3'h2);
        check({44'h0, fault_take, hard_fault}, 48'h4);
        rst_check();
        print_verdict();
    end
endmodule
bind shp_handler_regs shp_handler_regs_chk shp_handler_regs_chk_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .act_set(act_set), .mon_act_in(mon_act_in),
    .fault_req(fault_req), .fault_take(fault_take), .hard_fault(hard_fault),
    .pend_out(pend_out), .act_out(act_out), .enable_out(enable_out), .prio_out(prio_out));
